// >>> rtl/carc_pkg.sv
package carc_pkg;
	// ------------------------------------------------------------
	// Widths and encodings
	// ------------------------------------------------------------
	localparam int POS_W = 32;
	localparam logic [1:0] CODE_PREV = 2'h0;
	localparam logic [1:0] CODE_INIT = 2'h1;
	localparam logic [1:0] CODE_CALC = 2'h2;
	localparam logic [1:0] TGT_CYCLE = 2'h0;
	localparam logic [1:0] TGT_BASE = 2'h1;
	localparam logic [1:0] TGT_FEED = 2'h2;
	localparam logic [1:0] BASE_FEED = 2'h0;
	localparam logic [1:0] BASE_INIT = 2'h1;
	localparam logic [1:0] BASE_PREV = 2'h2;
	localparam logic [1:0] AXSEL_OUT = 2'h1;
	localparam logic [1:0] AXSEL_ENC = 2'h2;
	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [1:0] RST_CODE = 2'h0;
	localparam logic [15:0] RST_CLUTCH = 16'h0000;
	localparam logic [15:0] RST_TIME_MS = 16'h0000;
	localparam logic [31:0] RST_POS = 32'h0000_0000;

	// Methods written by the host, latched at switching
	typedef struct packed {
		logic [1:0] main_cycle_set_method;
		logic [1:0] cam_restore_target;
		logic [1:0] cam_base_set_method;
		logic [1:0] cam_cycle_set_method;
		logic [1:0] main_axis_select;
	} carc_sel_t;

	// Numeric settings written by the host, latched at switching
	typedef struct packed {
		logic [31:0] main_cycle_init_value;
		logic [31:0] cam_base_init_value;
		logic [31:0] cam_cycle_init_value;
		logic [31:0] cam_cycle_length;
		logic [15:0] clutch_ctrl_setting;
		logic [15:0] clutch_smooth_system;
		logic [15:0] clutch_smooth_time;
		logic [15:0] cam_comp_time_const;
	} carc_val_t;

	// Live positions supplied by the axis logic
	typedef struct packed {
		logic [31:0] feed_pos;
		logic [31:0] input_axis_cycle;
		logic [31:0] last_base_pos;
		logic [31:0] last_cam_cycle;
	} carc_pos_t;
endpackage

// >>> rtl/carc_code_hold.sv
`timescale 1ns/1ps
// Holds a two-bit selection code; only codes 0, 1, 2 replace the held one
module carc_code_hold (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic load,
	input wire logic [1:0] code_in,
	output logic [1:0] code_out,
	output logic bad
);
	import carc_pkg::*;
	logic [1:0] code_r;
	logic [1:0] code_nxt;
	logic bad_r;
	logic bad_nxt;

	// --------------------------------------------------------------
	// Next value
	// --------------------------------------------------------------
	always_comb begin
		code_nxt = code_r;
		bad_nxt = bad_r;
		if (load) begin
			// Code 3 would be undefined downstream, so keep the old one
			if (code_in == CODE_PREV || code_in == CODE_INIT || code_in == CODE_CALC) begin
				code_nxt = code_in;
				bad_nxt = 1'b0;
			end else begin
				bad_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			code_r <= RST_CODE;
			bad_r <= 1'b0;
		end else begin
			code_r <= code_nxt;
			bad_r <= bad_nxt;
		end
	end

	assign code_out = code_r;
	assign bad = bad_r;
endmodule

// >>> rtl/carc_restore.sv
`timescale 1ns/1ps
// Operation
// - Marked settings take effect only at cam control switching; old values stay meanwhile.
// - Main cycle method: 0 previous, 1 initial value, 2 calculated from input axis.
// - Restore target: 0 one-cycle value, 1 standard position, 2 feed value.
// - Base method for cycle restore: 0 feed, 1 initial base, 2 previous.
// - Save last standard position as previous; if none saved, store feed value.
// - For targets 1 and 2, cam cycle method: 0 previous, 1 initial, 2 main cycle.
// - Save last cam cycle value as previous; cleared at power-off.
// - Initial value unit follows axis selection: 1 output unit, 2 encoder unit.
// - Clutch smoothing and compensation time constants are milliseconds, reset zero.
// - Clutch control setting resets to 0000h.
module carc_restore (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic cam_switch,
	input wire logic cam_end,
	input wire logic base_saved_in,
	input wire carc_pkg::carc_sel_t sel_in,
	input wire carc_pkg::carc_val_t val_in,
	input wire carc_pkg::carc_pos_t pos_in,
	output carc_pkg::carc_val_t val_act,
	output logic [1:0] restore_target,
	output logic unit_from_encoder,
	output logic [31:0] main_cycle_start,
	output logic [31:0] cam_base_start,
	output logic [31:0] cam_cycle_start,
	output logic start_valid,
	output logic code_error
);
	import carc_pkg::*;

	// --------------------------------------------------------------
	// Validated selection codes
	// --------------------------------------------------------------
	logic [1:0] code_in [4];
	logic [1:0] code_q [4];
	logic [3:0] bad_q;
	assign code_in[0] = sel_in.main_cycle_set_method;
	assign code_in[1] = sel_in.cam_restore_target;
	assign code_in[2] = sel_in.cam_base_set_method;
	assign code_in[3] = sel_in.cam_cycle_set_method;

	// One holder per selection code, each loaded only at switching
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_code
			carc_code_hold u_hold (
				.ref_clk(ref_clk),
				.reset(reset),
				.load(cam_switch),
				.code_in(code_in[gi]),
				.code_out(code_q[gi]),
				.bad(bad_q[gi])
			);
		end
	endgenerate

	// --------------------------------------------------------------
	// Settings latch and previous-value store
	// --------------------------------------------------------------
	carc_val_t val_r;
	carc_val_t val_nxt;
	logic [1:0] axsel_r;
	logic [1:0] axsel_nxt;
	logic [31:0] prev_main_r;
	logic [31:0] prev_main_nxt;
	logic [31:0] prev_base_r;
	logic [31:0] prev_base_nxt;
	logic [31:0] prev_cycle_r;
	logic [31:0] prev_cycle_nxt;
	logic pending_r;
	logic pending_nxt;
	logic unit_enc_r;
	logic unit_enc_nxt;

	// Host data is only copied at switching, so a control in progress sees stable values
	always_comb begin
		val_nxt = val_r;
		axsel_nxt = axsel_r;
		prev_main_nxt = prev_main_r;
		prev_base_nxt = prev_base_r;
		prev_cycle_nxt = prev_cycle_r;
		pending_nxt = 1'b0;
		if (cam_switch) begin
			val_nxt = val_in;
			// Axis selection only 1 or 2 is meaningful; others keep the old unit
			if (sel_in.main_axis_select == AXSEL_OUT || sel_in.main_axis_select == AXSEL_ENC) begin
				axsel_nxt = sel_in.main_axis_select;
			end
			pending_nxt = 1'b1;
		end
		// At the end of a cam control the last values become the previous ones
		if (cam_end) begin
			prev_main_nxt = pos_in.input_axis_cycle;
			prev_cycle_nxt = pos_in.last_cam_cycle;
			// Without a saved standard position the feed value stands in
			prev_base_nxt = base_saved_in ? pos_in.last_base_pos : pos_in.feed_pos;
		end
		// Unit flag registered here so the output comes straight from a flip-flop
		unit_enc_nxt = (axsel_nxt == AXSEL_ENC);
	end

	// Reset models power-off: the previous values are lost
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			val_r <= '{RST_POS, RST_POS, RST_POS, RST_POS, RST_CLUTCH, RST_TIME_MS, RST_TIME_MS, RST_TIME_MS};
			axsel_r <= AXSEL_OUT;
			prev_main_r <= RST_POS;
			prev_base_r <= RST_POS;
			prev_cycle_r <= RST_POS;
			pending_r <= 1'b0;
			unit_enc_r <= 1'b0;
		end else begin
			val_r <= val_nxt;
			axsel_r <= axsel_nxt;
			prev_main_r <= prev_main_nxt;
			prev_base_r <= prev_base_nxt;
			prev_cycle_r <= prev_cycle_nxt;
			pending_r <= pending_nxt;
			unit_enc_r <= unit_enc_nxt;
		end
	end

	// --------------------------------------------------------------
	// Start-value selection
	// --------------------------------------------------------------
	logic [31:0] main_start_r;
	logic [31:0] main_start_nxt;
	logic [31:0] base_start_r;
	logic [31:0] base_start_nxt;
	logic [31:0] cycle_start_r;
	logic [31:0] cycle_start_nxt;
	logic valid_r;
	logic valid_nxt;

	// Selection runs one cycle after switching, once the codes are held
	always_comb begin
		main_start_nxt = main_start_r;
		base_start_nxt = base_start_r;
		cycle_start_nxt = cycle_start_r;
		valid_nxt = 1'b0;
		if (pending_r) begin
			valid_nxt = 1'b1;
			unique case (code_q[0])
				CODE_PREV: main_start_nxt = prev_main_r;
				CODE_INIT: main_start_nxt = val_r.main_cycle_init_value;
				CODE_CALC: main_start_nxt = pos_in.input_axis_cycle;
				default: main_start_nxt = main_start_r;
			endcase
			if (code_q[1] == TGT_CYCLE) begin
				// Cycle restore searches from a standard position
				unique case (code_q[2])
					BASE_FEED: base_start_nxt = pos_in.feed_pos;
					BASE_INIT: base_start_nxt = val_r.cam_base_init_value;
					BASE_PREV: base_start_nxt = prev_base_r;
					default: base_start_nxt = base_start_r;
				endcase
				cycle_start_nxt = cycle_start_r;
			end else begin
				// Base or feed restore: the cycle value is the given one
				base_start_nxt = (code_q[1] == TGT_FEED) ? pos_in.feed_pos : base_start_r;
				unique case (code_q[3])
					CODE_PREV: cycle_start_nxt = prev_cycle_r;
					CODE_INIT: cycle_start_nxt = val_r.cam_cycle_init_value;
					CODE_CALC: cycle_start_nxt = main_start_nxt;
					default: cycle_start_nxt = cycle_start_r;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			main_start_r <= RST_POS;
			base_start_r <= RST_POS;
			cycle_start_r <= RST_POS;
			valid_r <= 1'b0;
		end else begin
			main_start_r <= main_start_nxt;
			base_start_r <= base_start_nxt;
			cycle_start_r <= cycle_start_nxt;
			valid_r <= valid_nxt;
		end
	end

	// --------------------------------------------------------------
	// Outputs, all from flip-flops
	// --------------------------------------------------------------
	logic err_r;
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			err_r <= 1'b0;
		end else begin
			err_r <= |bad_q;
		end
	end

	assign val_act = val_r;
	assign restore_target = code_q[1];
	assign unit_from_encoder = unit_enc_r;
	assign main_cycle_start = main_start_r;
	assign cam_base_start = base_start_r;
	assign cam_cycle_start = cycle_start_r;
	assign start_valid = valid_r;
	assign code_error = err_r;
endmodule

// >>> dv/carc_restore_asserts.sv
`timescale 1ns/1ps
module carc_restore_chk (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic cam_switch,
	input wire logic cam_end,
	input wire logic base_saved_in,
	input wire carc_pkg::carc_sel_t sel_in,
	input wire carc_pkg::carc_val_t val_in,
	input wire carc_pkg::carc_pos_t pos_in,
	input wire carc_pkg::carc_val_t val_act,
	input wire logic [1:0] restore_target,
	input wire logic unit_from_encoder,
	input wire logic [31:0] main_cycle_start,
	input wire logic [31:0] cam_base_start,
	input wire logic [31:0] cam_cycle_start,
	input wire logic start_valid,
	input wire logic code_error
);
	import carc_pkg::*;
	// One domain, so one clock and one disable for all
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	a_latch_settings: assert property (cam_switch |=> val_act == $past(val_in)) else $error("not latched");
	a_hold_settings: assert property (!cam_switch |=> $stable(val_act)) else $error("moved early");
	a_valid_delay: assert property (cam_switch |-> ##2 start_valid) else $error("no start");
	a_valid_cause: assert property (start_valid |-> $past(cam_switch, 2)) else $error("stray start");
	a_main_init: assert property (cam_switch && sel_in.main_cycle_set_method == CODE_INIT |->
		##2 main_cycle_start == $past(val_in.main_cycle_init_value, 2)) else $error("main init");
	a_feed_base: assert property (cam_switch && sel_in.cam_restore_target == TGT_FEED |->
		##2 cam_base_start == $past(pos_in.feed_pos, 1)) else $error("feed base");
	a_cycle_init: assert property (cam_switch && sel_in.cam_restore_target != TGT_CYCLE &&
		sel_in.cam_restore_target != 2'h3 && sel_in.cam_cycle_set_method == CODE_INIT |->
		##2 cam_cycle_start == $past(val_in.cam_cycle_init_value, 2)) else $error("cycle init");
	a_bad_target: assert property (cam_switch && sel_in.cam_restore_target == 2'h3 |->
		##1 $stable(restore_target) ##1 code_error) else $error("bad code");
	a_unit_enc: assert property (cam_switch && sel_in.main_axis_select == AXSEL_ENC |=> unit_from_encoder)
		else $error("unit");
	c_bad: cover property (code_error);
	c_enc: cover property (unit_from_encoder);
	c_feed: cover property (cam_switch && sel_in.cam_restore_target == TGT_FEED);
endmodule
bind carc_restore carc_restore_chk i_carc_restore_chk (.ref_clk, .reset, .cam_switch, .cam_end, .base_saved_in,
	.sel_in, .val_in, .pos_in, .val_act, .restore_target, .unit_from_encoder, .main_cycle_start,
	.cam_base_start, .cam_cycle_start, .start_valid, .code_error);

// >>> dv/carc_host_model.sv
`timescale 1ns/1ps
module carc_host_model (
	input wire logic req,
	input wire carc_pkg::carc_sel_t sel,
	input wire carc_pkg::carc_val_t val,
	output logic cam_switch,
	output carc_pkg::carc_sel_t sel_in,
	output carc_pkg::carc_val_t val_in
);
	import carc_pkg::*;
	carc_val_t v;
	// Settings are valid only with the switch; scrambled after it, so late latching shows
	always_comb begin
		v = val;
		if (v.main_cycle_init_value >= v.cam_cycle_length)
			v.main_cycle_init_value = '0;
		cam_switch = req;
		sel_in = req ? sel : ~sel;
		val_in = req ? v : ~v;
	end
endmodule

// >>> dv/testbench.sv
`timescale 1ns/1ps
module testbench;
	import carc_pkg::*;
	logic ref_clk = 0, reset = 1, req = 0, cam_end = 0, base_saved_in = 0;
	logic cam_switch, unit_from_encoder, start_valid, code_error;
	logic [1:0] restore_target, last_t = 0;
	logic [31:0] main_cycle_start, cam_base_start, cam_cycle_start, pm, pb, pc;
	carc_sel_t sel = '0, sel_in;
	carc_val_t val, val_in, val_act;
	carc_pos_t pos_in = '0;
	int fails = 0, checks_done = 0;
	always #12.5 ref_clk = ~ref_clk;
	carc_host_model i_carc_host_model (.req, .sel, .val, .cam_switch, .sel_in, .val_in);
	carc_restore i_carc_restore (.ref_clk, .reset, .cam_switch, .cam_end, .base_saved_in, .sel_in, .val_in,
		.pos_in, .val_act, .restore_target, .unit_from_encoder, .main_cycle_start, .cam_base_start,
		.cam_cycle_start, .start_valid, .code_error);
	task automatic cmp(input logic [191:0] got, input logic [191:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// End a cam run; live positions then move so saved and live differ
	task automatic end_run(input logic [31:0] k, input logic saved);
		pos_in = {k + 32'hF0, k + 32'hA0, k + 32'hB0, k + 32'hC0};
		base_saved_in = saved;
		cam_end = 1;
		@(negedge ref_clk) cam_end = 0;
		pm = k + 32'hA0;
		pb = saved ? k + 32'hB0 : k + 32'hF0;
		pc = k + 32'hC0;
		pos_in = {k + 32'hF8, k + 32'hA8, k + 32'hB8, k + 32'hC8};
	endtask
	task automatic switch_to(input logic [1:0] m, t, b, c, a);
		logic [31:0] em;
		logic [1:0] tt;
		sel = {m, t, b, c, a};
		req = 1;
		@(negedge ref_clk) req = 0;
		@(negedge ref_clk);
		// A refused target code leaves the last valid one in force
		tt = t == 2'h3 ? last_t : t;
		last_t = tt;
		cmp(val_act, val);
		cmp(restore_target, tt);
		cmp(unit_from_encoder, a == AXSEL_ENC);
		cmp(start_valid, 1'h1);
		@(negedge ref_clk);
		cmp(code_error, t == 2'h3);
		em = m == CODE_PREV ? pm : m == CODE_INIT ? val.main_cycle_init_value : pos_in.input_axis_cycle;
		cmp(main_cycle_start, em);
		if (tt == TGT_CYCLE) begin
			cmp(cam_base_start, b == BASE_FEED ? pos_in.feed_pos : b == BASE_INIT ? val.cam_base_init_value : pb);
		end else begin
			cmp(cam_cycle_start, c == CODE_PREV ? pc : c == CODE_INIT ? val.cam_cycle_init_value : em);
		end
		if (tt == TGT_FEED) begin
			cmp(cam_base_start, pos_in.feed_pos);
		end
		cmp(start_valid, 1'h0);
	endtask
	task automatic report_and_stop;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Main sequence: reset values, every method code, fallback, bad code, power-off
	initial begin
		val = {32'h11, 32'h22, 32'h33, 32'h100, 16'h0000, 16'h0001, 16'h0005, 16'h0007};
		repeat (5) @(negedge ref_clk);
		cmp(val_act, '0);
		reset = 0;
		end_run(0, 1);
		switch_to(0, 0, 2, 0, 1);
		switch_to(1, 0, 0, 0, 2);
		switch_to(2, 0, 1, 0, 1);
		switch_to(0, 1, 0, 0, 1);
		switch_to(1, 2, 0, 1, 2);
		switch_to(2, 2, 0, 2, 1);
		$display("methods test done");
		end_run(32'h10, 0);
		switch_to(0, 0, 2, 0, 1);
		switch_to(0, 3, 0, 0, 1);
		$display("fallback test done");
		reset = 1;
		@(negedge ref_clk) reset = 0;
		{pm, pb, pc, last_t} = '0;
		switch_to(0, 1, 2, 0, 1);
		$display("power-off test done");
		report_and_stop;
	end
	// Whole run is near 35 cycles; this cuts a hang
	initial begin
		#20000;
		fails++;
		report_and_stop;
	end
endmodule
